// *** design/tcc_pkg.sv ***
// tcc_pkg: constants for the timer capture/compare/one-pulse block
// assumes an apb slave with 32-bit data, one register per aligned word
package tcc_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_CAP1_HI  = 8'h0C;
  localparam logic [7:0] ADDR_CAP1_LO  = 8'h10;
  localparam logic [7:0] ADDR_CAP2_HI  = 8'h14;
  localparam logic [7:0] ADDR_CAP2_LO  = 8'h18;
  localparam logic [7:0] ADDR_CMP1_HI  = 8'h1C;
  localparam logic [7:0] ADDR_CMP1_LO  = 8'h20;
  localparam logic [7:0] ADDR_CMP2_HI  = 8'h24;
  localparam logic [7:0] ADDR_CMP2_LO  = 8'h28;
  localparam logic [7:0] ADDR_COUNTER  = 8'h2C;
  // ---------------------------------------------------------------
  // control one fields
  // ---------------------------------------------------------------
  localparam int C1_CAP_IE    = 7;
  localparam int C1_CMP_IE    = 6;
  localparam int C1_FORCE2    = 4;
  localparam int C1_FORCE1    = 3;
  localparam int C1_EDGE1     = 2;
  localparam int C1_LEVEL2    = 1;
  localparam int C1_LEVEL1    = 0;
  // ---------------------------------------------------------------
  // control two fields
  // ---------------------------------------------------------------
  localparam int C2_OUT_EN1   = 7;
  localparam int C2_OUT_EN2   = 6;
  localparam int C2_ONE_PULSE = 5;
  localparam int C2_PWM       = 4;
  localparam int C2_CLK_HI    = 3;
  localparam int C2_CLK_LO    = 2;
  localparam int C2_EDGE2     = 1;
  localparam int C2_EXT_EDGE  = 0;
  // ---------------------------------------------------------------
  // status fields
  // ---------------------------------------------------------------
  localparam int ST_CAP1 = 7;
  localparam int ST_CMP1 = 6;
  localparam int ST_CAP2 = 4;
  localparam int ST_CMP2 = 3;
  // ---------------------------------------------------------------
  // values
  // ---------------------------------------------------------------
  localparam logic [15:0] COUNT_RELOAD  = 16'hFFFC;
  localparam logic [15:0] PULSE_CAPTURE = 16'hFFFD;
  localparam logic [15:0] COMPARE_RESET = 16'h8000;
  localparam logic [2:0]  DIV2_LAST     = 3'h1;
  localparam logic [2:0]  DIV4_LAST     = 3'h3;
  localparam logic [2:0]  DIV8_LAST     = 3'h7;
endpackage : tcc_pkg

// *** design/tcc_timer.sv ***
// tcc_timer: capture, compare, forced output and one-pulse timer core
// assumes apb master on clk, pins asynchronous to clk, cpu mask as input
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
// Notes on behaviour
// RQ1: active capture edge latches counter, sets flag
// RQ2: capture irq needs enable and clear mask
// RQ3: capture flag clears: status read, low access
// RQ4: high byte read blocks capture until low
// RQ5: newest capture overwrites older value
// RQ6: capture works even when pin drives output
// RQ7: one pulse/pwm: only capture two captures
// RQ8: compare match sets flag, drives pin
// RQ9: compare regs software only, reset 8000h
// RQ10: compare pin latches low during reset
// RQ11: high byte write suspends compare until low
// RQ12: compare flag clears: status read, low access
// RQ13: software writes high, reads status, writes low
// RQ14: output disabled: no pin level, irq allowed
// RQ15: flag and pin act while counter equals
// RQ16: force copies level, no flag, ignored modes
// RQ17: one pulse uses capture one, compare one
// RQ18: pulse edge: reload, level two, flag, FFFDh
// RQ19: pulse ends at compare one, level one
// RQ20: one pulse never sets compare flag one
// RQ21: pwm wins over one pulse
// RQ22: compare two usable, level two for pulse
// RQ23: counter reset and reload value FFFCh
// RQ24: clock select: div 2, 4, 8 or external
// RQ25: capture pins synchronised before edge detect
module tcc_timer (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        capture_pin1,
  input  wire logic        capture_pin2,
  input  wire logic        ext_clock_pin,
  input  wire logic        cpu_irq_mask,
  output logic             compare_pin1,
  output logic             compare_pin2,
  output logic             compare_pin1_oe_b,
  output logic             compare_pin2_oe_b,
  output logic             timer_irq
);
  // ---------------------------------------------------------------
  // registers and bus decode
  // ---------------------------------------------------------------
  logic [7:0]  ctrl_one_reg;
  logic [7:0]  ctrl_two_reg;
  logic [15:0] counter_reg;
  logic [15:0] cap1_reg;
  logic [15:0] cap2_reg;
  logic [15:0] cmp1_reg;
  logic [15:0] cmp2_reg;
  logic [3:0]  flag_reg;   // cap1, cmp1, cap2, cmp2
  logic [3:0]  seen_reg;   // status read saw the flag set
  logic        cap1_block_reg;
  logic        cap2_block_reg;
  logic        cmp1_hold_reg;
  logic        cmp2_hold_reg;
  logic [2:0]  presc_reg;
  logic [2:0]  cap1_sync_reg;
  logic [2:0]  cap2_sync_reg;
  logic [2:0]  ext_sync_reg;
  logic        pin1_reg;
  logic        pin2_reg;
  logic        access;
  logic        wr;
  logic        rd;
  logic        tick;
  logic        pwm_mode;
  logic        pulse_mode;
  logic        cap1_edge;
  logic        cap2_edge;
  logic        match1;
  logic        match2;
  logic        pulse_start;
  logic [7:0]  status_byte;
  logic [2:0]  presc_last;
  logic [3:0]  low_access;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  function automatic logic edge_ok(input logic [2:0] s, input logic rising);
    edge_ok = rising ? (s[1] & ~s[2]) : (~s[1] & s[2]);
  endfunction : edge_ok

  assign access  = psel & penable;
  assign wr      = access & pwrite;
  assign rd      = access & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  assign pwm_mode   = ctrl_two_reg[tcc_pkg::C2_PWM];
  assign pulse_mode = ctrl_two_reg[tcc_pkg::C2_ONE_PULSE] & ~pwm_mode;  // [RQ21]
  assign status_byte = {flag_reg[3], flag_reg[2], 1'b0, flag_reg[1], flag_reg[0], 3'h0};

  // read or write to a low byte counts as the second clearing step
  assign low_access = {access & hit(paddr, tcc_pkg::ADDR_CAP1_LO),
                       access & hit(paddr, tcc_pkg::ADDR_CMP1_LO),
                       access & hit(paddr, tcc_pkg::ADDR_CAP2_LO),
                       access & hit(paddr, tcc_pkg::ADDR_CMP2_LO)};

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // bit 0 is only read by bit 1; edges are taken between bits 1 and 2
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cap1_sync_reg <= 3'h0;
      cap2_sync_reg <= 3'h0;
      ext_sync_reg  <= 3'h0;
    end else begin
      cap1_sync_reg <= {cap1_sync_reg[1:0], capture_pin1};  // [RQ25]
      cap2_sync_reg <= {cap2_sync_reg[1:0], capture_pin2};  // [RQ25]
      ext_sync_reg  <= {ext_sync_reg[1:0], ext_clock_pin};
    end
  end

  // pin level is sampled even while driven as output [RQ6]
  assign cap1_edge = edge_ok(cap1_sync_reg, ctrl_one_reg[tcc_pkg::C1_EDGE1]);
  assign cap2_edge = edge_ok(cap2_sync_reg, ctrl_two_reg[tcc_pkg::C2_EDGE2]);

  // ---------------------------------------------------------------
  // prescaler and counter
  // ---------------------------------------------------------------
  always_comb begin
    case (ctrl_two_reg[tcc_pkg::C2_CLK_HI:tcc_pkg::C2_CLK_LO])
      2'h0:    presc_last = tcc_pkg::DIV4_LAST;
      2'h1:    presc_last = tcc_pkg::DIV2_LAST;
      default: presc_last = tcc_pkg::DIV8_LAST;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      presc_reg <= 3'h0;
    end else if (presc_reg >= presc_last) begin
      presc_reg <= 3'h0;
    end else begin
      presc_reg <= presc_reg + 3'h1;
    end
  end

  always_comb begin
    if (&ctrl_two_reg[tcc_pkg::C2_CLK_HI:tcc_pkg::C2_CLK_LO]) begin  // [RQ24]
      tick = edge_ok(ext_sync_reg, ctrl_two_reg[tcc_pkg::C2_EXT_EDGE]);
    end else begin
      tick = (presc_reg >= presc_last);  // [RQ24]
    end
  end

  assign pulse_start = pulse_mode & cap1_edge;  // [RQ17]
  // compares run only on the tick cycle while the counter holds the value [RQ15]
  assign match1 = ~cmp1_hold_reg & (counter_reg == cmp1_reg) & tick;  // [RQ11]
  assign match2 = ~cmp2_hold_reg & (counter_reg == cmp2_reg) & tick;  // [RQ11]

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      counter_reg <= tcc_pkg::COUNT_RELOAD;  // [RQ23]
    end else if (pulse_start) begin
      counter_reg <= tcc_pkg::COUNT_RELOAD;  // [RQ18]
    end else if (wr && hit(paddr, tcc_pkg::ADDR_COUNTER)) begin
      counter_reg <= tcc_pkg::COUNT_RELOAD;  // [RQ23]
    end else if (pwm_mode && match2) begin
      counter_reg <= tcc_pkg::COUNT_RELOAD;  // [RQ23]
    end else if (tick) begin
      counter_reg <= counter_reg + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // force bits self-clear: they act as a one-cycle strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_one_reg <= 8'h00;
      ctrl_two_reg <= 8'h00;
    end else begin
      ctrl_one_reg[tcc_pkg::C1_FORCE1] <= 1'b0;
      ctrl_one_reg[tcc_pkg::C1_FORCE2] <= 1'b0;
      if (wr && hit(paddr, tcc_pkg::ADDR_CTRL_ONE)) begin
        ctrl_one_reg <= pwdata[7:0];
      end
      if (wr && hit(paddr, tcc_pkg::ADDR_CTRL_TWO)) begin
        ctrl_two_reg <= pwdata[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // compare registers, software only
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmp1_reg      <= tcc_pkg::COMPARE_RESET;  // [RQ9]
      cmp2_reg      <= tcc_pkg::COMPARE_RESET;  // [RQ9]
      cmp1_hold_reg <= 1'b0;
      cmp2_hold_reg <= 1'b0;
    end else if (wr) begin
      case (paddr)
        tcc_pkg::ADDR_CMP1_HI: begin
          cmp1_reg[15:8] <= pwdata[7:0];
          cmp1_hold_reg  <= 1'b1;  // [RQ11]
        end
        tcc_pkg::ADDR_CMP1_LO: begin
          cmp1_reg[7:0]  <= pwdata[7:0];
          cmp1_hold_reg  <= 1'b0;  // [RQ11]
        end
        tcc_pkg::ADDR_CMP2_HI: begin
          cmp2_reg[15:8] <= pwdata[7:0];
          cmp2_hold_reg  <= 1'b1;  // [RQ11]
        end
        tcc_pkg::ADDR_CMP2_LO: begin
          cmp2_reg[7:0]  <= pwdata[7:0];
          cmp2_hold_reg  <= 1'b0;  // [RQ11]
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // capture registers and blocking
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cap1_block_reg <= 1'b0;
      cap2_block_reg <= 1'b0;
    end else begin
      if (rd && hit(paddr, tcc_pkg::ADDR_CAP1_HI)) begin
        cap1_block_reg <= 1'b1;  // [RQ4]
      end else if (rd && hit(paddr, tcc_pkg::ADDR_CAP1_LO)) begin
        cap1_block_reg <= 1'b0;  // [RQ4]
      end
      if (rd && hit(paddr, tcc_pkg::ADDR_CAP2_HI)) begin
        cap2_block_reg <= 1'b1;  // [RQ4]
      end else if (rd && hit(paddr, tcc_pkg::ADDR_CAP2_LO)) begin
        cap2_block_reg <= 1'b0;  // [RQ4]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cap1_reg <= 16'h0000;
      cap2_reg <= 16'h0000;
    end else begin
      if (pulse_start) begin
        cap1_reg <= tcc_pkg::PULSE_CAPTURE;  // [RQ18]
      end else if (cap1_edge && !cap1_block_reg && !pwm_mode && !pulse_mode) begin
        cap1_reg <= counter_reg;  // [RQ1] [RQ5] [RQ7]
      end
      if (cap2_edge && !cap2_block_reg) begin
        cap2_reg <= counter_reg;  // [RQ1] [RQ5]
      end
    end
  end

  // ---------------------------------------------------------------
  // flags: set wins over clear
  // ---------------------------------------------------------------
  // a blocked channel gets no new flag; one already set keeps its two-step clear
  logic [3:0] flag_set;
  always_comb begin
    flag_set[3] = (pulse_start | (cap1_edge & ~pwm_mode & ~pulse_mode)
                  | (pwm_mode & match2)) & ~cap1_block_reg;  // [RQ1] [RQ18] [RQ4]
    flag_set[2] = match1 & ~pwm_mode & ~pulse_mode;  // [RQ8] [RQ20]
    flag_set[1] = cap2_edge & ~cap2_block_reg;  // [RQ1] [RQ4]
    flag_set[0] = match2 & ~pwm_mode;  // [RQ8] [RQ22]
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_reg <= 4'h0;
      seen_reg <= 4'h0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (flag_set[k]) begin
          flag_reg[k] <= 1'b1;
        end else if (seen_reg[k] && low_access[k]) begin
          flag_reg[k] <= 1'b0;  // [RQ3] [RQ12]
        end
        if (rd && hit(paddr, tcc_pkg::ADDR_STATUS)) begin
          seen_reg[k] <= flag_reg[k];
        end else if (low_access[k]) begin
          seen_reg[k] <= 1'b0;
        end
      end
    end
  end

  // level-sensitive, stays pending while masked
  assign timer_irq = ~cpu_irq_mask
                   & ((ctrl_one_reg[tcc_pkg::C1_CAP_IE] & (flag_reg[3] | flag_reg[1]))
                   |  (ctrl_one_reg[tcc_pkg::C1_CMP_IE] & (flag_reg[2] | flag_reg[0])));  // [RQ2]

  // ---------------------------------------------------------------
  // compare pins
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin1_reg <= 1'b0;  // [RQ10]
      pin2_reg <= 1'b0;  // [RQ10]
    end else begin
      if (pulse_start) begin
        pin1_reg <= ctrl_one_reg[tcc_pkg::C1_LEVEL2];  // [RQ18] [RQ22]
      end else if ((pulse_mode || pwm_mode) && match1) begin
        pin1_reg <= ctrl_one_reg[tcc_pkg::C1_LEVEL1];  // [RQ19]
      end else if (pwm_mode && match2) begin
        pin1_reg <= ctrl_one_reg[tcc_pkg::C1_LEVEL2];
      end else if (!pulse_mode && !pwm_mode
                   && (match1 || ctrl_one_reg[tcc_pkg::C1_FORCE1])) begin
        pin1_reg <= ctrl_one_reg[tcc_pkg::C1_LEVEL1];  // [RQ8] [RQ16]
      end
      if (!pulse_mode && !pwm_mode
          && (match2 || ctrl_one_reg[tcc_pkg::C1_FORCE2])) begin
        pin2_reg <= ctrl_one_reg[tcc_pkg::C1_LEVEL2];  // [RQ8] [RQ16] [RQ20]
      end
    end
  end

  assign compare_pin1      = pin1_reg;
  assign compare_pin2      = pin2_reg;
  assign compare_pin1_oe_b = ~ctrl_two_reg[tcc_pkg::C2_OUT_EN1];  // [RQ14]
  assign compare_pin2_oe_b = ~ctrl_two_reg[tcc_pkg::C2_OUT_EN2];  // [RQ14]

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      tcc_pkg::ADDR_CTRL_ONE: prdata[7:0] = ctrl_one_reg;
      tcc_pkg::ADDR_CTRL_TWO: prdata[7:0] = ctrl_two_reg;
      tcc_pkg::ADDR_STATUS:   prdata[7:0] = status_byte;
      tcc_pkg::ADDR_CAP1_HI:  prdata[7:0] = cap1_reg[15:8];
      tcc_pkg::ADDR_CAP1_LO:  prdata[7:0] = cap1_reg[7:0];
      tcc_pkg::ADDR_CAP2_HI:  prdata[7:0] = cap2_reg[15:8];
      tcc_pkg::ADDR_CAP2_LO:  prdata[7:0] = cap2_reg[7:0];
      tcc_pkg::ADDR_CMP1_HI:  prdata[7:0] = cmp1_reg[15:8];
      tcc_pkg::ADDR_CMP1_LO:  prdata[7:0] = cmp1_reg[7:0];
      tcc_pkg::ADDR_CMP2_HI:  prdata[7:0] = cmp2_reg[15:8];
      tcc_pkg::ADDR_CMP2_LO:  prdata[7:0] = cmp2_reg[7:0];
      tcc_pkg::ADDR_COUNTER:  prdata[15:0] = counter_reg;
      default:                prdata = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_cap_load: assert property (@(posedge clk) disable iff (!rst_b) // [RQ1]
    (cap2_edge && !cap2_block_reg) |=> (cap2_reg == $past(counter_reg)))
    else $error("capture two did not latch counter");
  a_cap_block: assert property (@(posedge clk) disable iff (!rst_b) // [RQ4]
    cap2_block_reg |=> (!$rose(flag_reg[1]) && $stable(cap2_reg)))
    else $error("blocked capture changed");
  a_irq_mask: assert property (@(posedge clk) disable iff (!rst_b) // [RQ2]
    cpu_irq_mask |-> !timer_irq)
    else $error("irq raised while masked");
  a_cmp_flag: assert property (@(posedge clk) disable iff (!rst_b) // [RQ8]
    (match2 && !pwm_mode) |=> flag_reg[0])
    else $error("compare two flag not set");
  a_cmp_hold: assert property (@(posedge clk) disable iff (!rst_b) // [RQ11]
    cmp1_hold_reg |=> !$rose(flag_reg[2]))
    else $error("compare ran while suspended");
  a_pulse_start: assert property (@(posedge clk) disable iff (!rst_b) // [RQ18]
    pulse_start |=> (counter_reg == tcc_pkg::COUNT_RELOAD
                     && cap1_reg == tcc_pkg::PULSE_CAPTURE && flag_reg[3]))
    else $error("pulse start effects missing");
  a_pulse_no_flag: assert property (@(posedge clk) disable iff (!rst_b) // [RQ20]
    (pulse_mode && !flag_reg[2]) |=> !flag_reg[2])
    else $error("compare one flag set in one pulse");
  a_pulse_end: assert property (@(posedge clk) disable iff (!rst_b) // [RQ19]
    (pulse_mode && match1 && !pulse_start)
      |=> (pin1_reg == $past(ctrl_one_reg[tcc_pkg::C1_LEVEL1])))
    else $error("pulse did not end at compare");
  c_pulse: cover property (@(posedge clk) disable iff (!rst_b) pulse_start);
  c_cap2: cover property (@(posedge clk) disable iff (!rst_b) flag_set[1]);
  c_cmp1: cover property (@(posedge clk) disable iff (!rst_b) match1 && !pulse_mode);
endmodule : tcc_timer

// *** bench/tcc_pin_source.sv ***
// tcc_pin_source: external pulse sources on the capture pins and a free clock
// assumes fire requests arrive as one-cycle pulses on clk
`timescale 1ns/100ps
module tcc_pin_source (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic fire1,
  input  wire logic fire2,
  input  wire logic [3:0] hold,
  output logic      capture_pin1,
  output logic      capture_pin2,
  output logic      ext_clock_pin
);
  // ---------------------------------------------------------------
  // pulse sources
  // ---------------------------------------------------------------
  logic [3:0] left1_reg;
  logic [3:0] left2_reg;
  logic [3:0] div_reg;
  // pulses held for hold cycles so the 3-flop sync always sees them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      left1_reg <= 4'h0;
      left2_reg <= 4'h0;
    end else begin
      left1_reg <= fire1 ? hold : (left1_reg != 4'h0 ? left1_reg - 4'h1 : 4'h0);
      left2_reg <= fire2 ? hold : (left2_reg != 4'h0 ? left2_reg - 4'h1 : 4'h0);
    end
  end
  assign capture_pin1 = (left1_reg != 4'h0);
  assign capture_pin2 = (left2_reg != 4'h0);
  // free running source, well below a quarter of clk
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) div_reg <= 4'h0;
    else        div_reg <= div_reg + 4'h1;
  end
  assign ext_clock_pin = div_reg[3];
endmodule : tcc_pin_source

// *** bench/tcc_timer_capture_compare_one_pulse_tb.sv ***
// tcc_timer_capture_compare_one_pulse_tb: self-checking bench of tcc_timer
// assumes zero-wait apb slave and the register map of tcc_pkg
`timescale 1ns/100ps
module timer_capture_compare_one_pulse_tb;
  typedef struct {logic [31:0] v; logic [31:0] m;} tcc_exp_t;
  logic clk, rst_b, psel, penable, pwrite, cpu_irq_mask, fire1, fire2;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic pready, pslverr, cap1, cap2, extc, pin1, pin2, oe1_b, oe2_b, irq;
  logic [31:0] seed;
  logic [15:0] cnt;
  int bad_count, num_checks, cyc;
  tcc_exp_t q[$];
  tcc_exp_t e;
  tcc_timer u_tcc_timer (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_pin1(cap1), .capture_pin2(cap2), .ext_clock_pin(extc),
    .cpu_irq_mask(cpu_irq_mask), .compare_pin1(pin1), .compare_pin2(pin2),
    .compare_pin1_oe_b(oe1_b), .compare_pin2_oe_b(oe2_b), .timer_irq(irq));
  tcc_pin_source u_tcc_pin_source (.clk(clk), .rst_b(rst_b), .fire1(fire1), .fire2(fire2),
    .hold(4'h6), .capture_pin1(cap1), .capture_pin2(cap2), .ext_clock_pin(extc));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic final_report;
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  // expectation noted first, the monitor compares when the data comes
  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
    q.push_back('{v, m});
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : wt
  task automatic cmp(input logic a, input logic x);
    num_checks++;
    if (a !== x) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, a, x);
    end
  endtask : cmp
  task automatic fire(input int n);
    @(posedge clk);
    if (n == 1) fire1 <= 1'b1;
    else fire2 <= 1'b1;
    @(posedge clk);
    fire1 <= 1'b0;
    fire2 <= 1'b0;
    wt(12);
  endtask : fire
  // ---------------------------------------------------------------
  // monitor, clock, timeout
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if ($sampled(psel && penable && pready && !pwrite) && q.size() > 0) begin
      e = q.pop_front();
      rdat = $sampled(prdata);
      num_checks++;
      if (((rdat ^ e.v) & e.m) !== 32'h0000_0000) begin
        bad_count++;
        $display("wrong value at %0t: got %h expected %h", $time, rdat, e.v);
      end
    end
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report;
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0000_0000; cpu_irq_mask = 1'b1; fire1 = 1'b0; fire2 = 1'b0;
    seed = 32'hde51_b7d5;
    wt(11);
    cmp(pin1, 1'b0);
    cmp(pin2, 1'b0);
    @(posedge clk);
    rst_b <= 1'b1;
    rd(tcc_pkg::ADDR_CMP1_HI, 32'h0000_0080, 32'hFFFF_FFFF);
    rd(tcc_pkg::ADDR_CMP1_LO, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(8'h3C, 32'h0000_0000, 32'hFFFF_FFFF);
    cmp(pslverr, 1'b0);
    seed = xs(seed);
    // compare two kept small so the counter passes it soon after reset and again after the one-pulse reload
    wr(tcc_pkg::ADDR_CMP2_HI, 32'h0000_0000);
    wr(tcc_pkg::ADDR_CMP2_LO, {24'h0, 3'h0, seed[4:0]});
    rd(tcc_pkg::ADDR_CMP2_HI, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(tcc_pkg::ADDR_CMP2_LO, {24'h0, 3'h0, seed[4:0]}, 32'hFFFF_FFFF);
    // capture one with the interrupt held off by the cpu mask
    wr(tcc_pkg::ADDR_CTRL_ONE, 32'h0000_0084);
    fire(1);
    cmp(irq, 1'b0);
    rd(tcc_pkg::ADDR_STATUS, 32'h0000_0080, 32'h0000_0080);
    cpu_irq_mask <= 1'b0;
    wt(1);
    cmp(irq, 1'b1);
    rd(tcc_pkg::ADDR_CAP1_HI, 32'h0, 32'h0);
    rd(tcc_pkg::ADDR_CAP1_LO, 32'h0, 32'h0);
    rd(tcc_pkg::ADDR_STATUS, 32'h0000_0000, 32'h0000_0080);
    // a pending high byte read blocks capture two
    wr(tcc_pkg::ADDR_CTRL_TWO, 32'h0000_0002);
    rd(tcc_pkg::ADDR_CAP2_HI, 32'h0, 32'h0);
    fire(2);
    rd(tcc_pkg::ADDR_STATUS, 32'h0000_0000, 32'h0000_0010);
    rd(tcc_pkg::ADDR_CAP2_LO, 32'h0, 32'h0);
    fire(2);
    rd(tcc_pkg::ADDR_STATUS, 32'h0000_0010, 32'h0000_0010);
    // compare one some ticks ahead, updated high, status, low
    wr(tcc_pkg::ADDR_CTRL_ONE, 32'h0000_0001);
    wr(tcc_pkg::ADDR_CTRL_TWO, 32'h0000_0082);
    rd(tcc_pkg::ADDR_COUNTER, 32'h0, 32'h0);
    @(posedge clk);
    cnt = rdat[15:0] + 16'h0010;
    wr(tcc_pkg::ADDR_CMP1_HI, {24'h0, cnt[15:8]});
    rd(tcc_pkg::ADDR_STATUS, 32'h0000_0000, 32'h0000_0040);
    wr(tcc_pkg::ADDR_CMP1_LO, {24'h0, cnt[7:0]});
    wt(120);
    cmp(pin1, 1'b1);
    cmp(oe1_b, 1'b0);
    cmp(oe2_b, 1'b1);
    rd(tcc_pkg::ADDR_STATUS, 32'h0000_0040, 32'h0000_0040);
    wr(tcc_pkg::ADDR_CMP1_LO, {24'h0, cnt[7:0]});
    rd(tcc_pkg::ADDR_STATUS, 32'h0000_0000, 32'h0000_0040);
    // forced level, no flag
    wr(tcc_pkg::ADDR_CTRL_ONE, 32'h0000_0008);
    wt(2);
    cmp(pin1, 1'b0);
    rd(tcc_pkg::ADDR_STATUS, 32'h0000_0000, 32'h0000_0040);
    // low access clears compare two flag, so the pulse phase must set it again
    rd(tcc_pkg::ADDR_CMP2_LO, {24'h0, 3'h0, seed[4:0]}, 32'hFFFF_FFFF);
    // one pulse: high during the pulse, low after compare one
    // mode first: an early match must not raise compare flag one
    wr(tcc_pkg::ADDR_CTRL_ONE, 32'h0000_0006);
    wr(tcc_pkg::ADDR_CTRL_TWO, 32'h0000_00A0);
    wr(tcc_pkg::ADDR_CMP1_HI, 32'h0000_0000);
    wr(tcc_pkg::ADDR_CMP1_LO, 32'h0000_0040);
    fire(1);
    cmp(pin1, 1'b1);
    rd(tcc_pkg::ADDR_CAP1_HI, 32'h0000_00FF, 32'hFFFF_FFFF);
    rd(tcc_pkg::ADDR_CAP1_LO, 32'h0000_00FD, 32'hFFFF_FFFF);
    wt(300);
    cmp(pin1, 1'b0);
    rd(tcc_pkg::ADDR_STATUS, 32'h0000_0008, 32'h0000_0048);
    wt(2);
    final_report;
  end
endmodule : timer_capture_compare_one_pulse_tb
